// *** logic/wtc_pkg.sv ***
package wtc_pkg;

  // Widths
  localparam int WIPER_W = 9;
  localparam int TAP_N = 257;
  localparam int TERMINAL_CONTROL_REG_W = 9;
  localparam int NET_MAX = 2;
  localparam int ADDR_W = 12;

  // Scale codes per resolution
  localparam logic [8:0] FS_8BIT = 9'h100;
  localparam logic [8:0] FS_7BIT = 9'h080;
  localparam logic [8:0] MID_8BIT = 9'h080;
  localparam logic [8:0] MID_7BIT = 9'h040;
  localparam logic [8:0] ZERO_CODE = 9'h000;
  localparam logic [8:0] ONE_CODE = 9'h001;

  // Values after reset and fixed read values
  localparam logic [8:0] TERMINAL_CONTROL_REG_RESET = 9'h1ff;
  localparam logic [8:0] RSVD5_VALUE = 9'h1f7;
  localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_WIPER0 = 6'h00;
  localparam logic [5:0] IDX_WIPER1 = 6'h01;
  localparam logic [5:0] IDX_TERMINAL_CONTROL_REG = 6'h04;
  localparam logic [5:0] IDX_RSVD5 = 6'h05;
  localparam logic [5:0] IDX_STEP_CMD = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h11;

  localparam logic [11:0] ADDR_WIPER0 = {4'h0, IDX_WIPER0, 2'b00};
  localparam logic [11:0] ADDR_WIPER1 = {4'h0, IDX_WIPER1, 2'b00};
  localparam logic [11:0] ADDR_TERMINAL_CONTROL_REG = {4'h0, IDX_TERMINAL_CONTROL_REG, 2'b00};
  localparam logic [11:0] ADDR_RSVD5 = {4'h0, IDX_RSVD5, 2'b00};
  localparam logic [11:0] ADDR_STEP_CMD = {4'h0, IDX_STEP_CMD, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {4'h0, IDX_STATUS, 2'b00};

  // Terminal-control field layout; network n occupies bits 4n+3..4n
  localparam int TERMINAL_CONTROL_REG_NET_STRIDE = 4;
  localparam int TERMINAL_CONTROL_REG_B_OFS = 0;
  localparam int TERMINAL_CONTROL_REG_W_OFS = 1;
  localparam int TERMINAL_CONTROL_REG_A_OFS = 2;
  localparam int TERMINAL_CONTROL_REG_HW_OFS = 3;
  localparam int TERMINAL_CONTROL_REG_GCEN_BIT = 8;

  // Step command register fields
  localparam int STEP_INC_BIT = 0;
  localparam int STEP_DEC_BIT = 1;
  localparam int STEP_NET_BIT = 4;

  // Status register fields
  localparam int STAT_SHDN_BIT0 = 0;
  localparam int STAT_FULL_BIT0 = 4;
  localparam int STAT_DUAL_BIT = 8;
  localparam int STAT_EIGHT_BIT = 9;

endpackage

// *** logic/wtc_tap_decode.sv ***
`timescale 1ns/1ps
module wtc_tap_decode
  import wtc_pkg::*;
#(
  parameter bit EIGHT_BIT = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Wiper code and applied terminal-control nibble
  input wire logic [WIPER_W-1:0] code_in,
  input wire logic [3:0] terminal_control_reg_nib_in,
  // Switch drives
  output logic [TAP_N-1:0] tap_sel_out,
  output logic term_a_out,
  output logic wiper_out,
  output logic term_b_out
);

  localparam logic [8:0] FS = EIGHT_BIT ? FS_8BIT : FS_7BIT;

  wire shutdown = !terminal_control_reg_nib_in[TERMINAL_CONTROL_REG_HW_OFS];
  wire above_fs = (code_in > FS);
  wire [8:0] clamped = above_fs ? FS : code_in;
  // Shutdown parks the tap at zero scale so W meets B through its own switch
  wire [8:0] pos = shutdown ? ZERO_CODE : clamped;
  wire [TAP_N-1:0] tap_nxt;

  // One comparator per tap; pos is a single value, so exactly one matches
  genvar i;
  generate
    for (i = 0; i < TAP_N; i++) begin : g_tap
      assign tap_nxt[i] = (pos == 9'(i));
    end
  endgenerate

  wire a_nxt = shutdown ? 1'b0 : terminal_control_reg_nib_in[TERMINAL_CONTROL_REG_A_OFS];
  wire w_nxt = shutdown ? 1'b1 : terminal_control_reg_nib_in[TERMINAL_CONTROL_REG_W_OFS];
  wire b_nxt = shutdown ? 1'b1 : terminal_control_reg_nib_in[TERMINAL_CONTROL_REG_B_OFS];

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tap_sel_out <= '0;
      term_a_out <= 1'b0;
      wiper_out <= 1'b0;
      term_b_out <= 1'b0;
    end else begin
      tap_sel_out <= tap_nxt;
      term_a_out <= a_nxt;
      wiper_out <= w_nxt;
      term_b_out <= b_nxt;
    end
  end

endmodule

// *** logic/wtc_ctrl.sv ***
`timescale 1ns/1ps
module wtc_ctrl
  import wtc_pkg::*;
#(
  parameter int NUM_NETS = 2,
  parameter bit EIGHT_BIT = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Network 0 switches
  output logic [TAP_N-1:0] net0_tap_sel_out,
  output logic net0_term_a_pin_out,
  output logic net0_wiper_pin_out,
  output logic net0_term_b_pin_out,
  // Network 1 switches
  output logic [TAP_N-1:0] net1_tap_sel_out,
  output logic net1_term_a_pin_out,
  output logic net1_wiper_pin_out,
  output logic net1_term_b_pin_out,
  // General call enable kept for the serial front end
  output logic gcen_out
);

  localparam logic [8:0] FS = EIGHT_BIT ? FS_8BIT : FS_7BIT;
  localparam logic [8:0] MID = EIGHT_BIT ? MID_8BIT : MID_7BIT;

  // APB phase decode
  wire setup_ph = psel_in && !penable_in;
  wire access_ph = psel_in && penable_in;
  wire wr_en = access_ph && pwrite_in;

  wire hit_w0 = (paddr_in == ADDR_WIPER0);
  wire hit_w1 = (paddr_in == ADDR_WIPER1) && (NUM_NETS > 1);
  wire hit_terminal_control_reg = (paddr_in == ADDR_TERMINAL_CONTROL_REG);
  wire hit_rsvd5 = (paddr_in == ADDR_RSVD5);
  wire hit_step = (paddr_in == ADDR_STEP_CMD);
  wire hit_stat = (paddr_in == ADDR_STATUS);
  wire addr_hit = hit_w0 || hit_w1 || hit_terminal_control_reg || hit_rsvd5 || hit_step || hit_stat;

  // Zero wait states; unmapped addresses answer with an error
  assign pready_out = access_ph;
  assign pslverr_out = access_ph && !addr_hit;

  // State
  logic [WIPER_W-1:0] wiper_r [NET_MAX];
  logic [WIPER_W-1:0] wiper_nxt [NET_MAX];
  logic [TERMINAL_CONTROL_REG_W-1:0] terminal_control_reg_r;
  logic [TERMINAL_CONTROL_REG_W-1:0] terminal_control_reg_app_r;
  logic [31:0] prdata_r;

  wire [NET_MAX-1:0] hit_wiper = {hit_w1, hit_w0};
  wire step_net = pwdata_in[STEP_NET_BIT];
  wire step_inc = pwdata_in[STEP_INC_BIT];
  wire step_dec = pwdata_in[STEP_DEC_BIT];

  logic [NET_MAX-1:0] shdn_now;
  logic [NET_MAX-1:0] full_now;
  logic [TAP_N-1:0] tap_sel [NET_MAX];
  logic [NET_MAX-1:0] pin_a;
  logic [NET_MAX-1:0] pin_w;
  logic [NET_MAX-1:0] pin_b;

  genvar n;
  generate
    for (n = 0; n < NET_MAX; n++) begin : g_net
      wire [WIPER_W-1:0] code = wiper_r[n];
      wire step_here = wr_en && hit_step && (step_net == 1'(n)) && (n < NUM_NETS);
      // Reserved codes sit above full scale and refuse both directions
      wire inc_ok = (code < FS);
      wire dec_ok = (code != ZERO_CODE) && (code <= FS);
      wire do_inc = step_here && step_inc && !step_dec && inc_ok;
      wire do_dec = step_here && step_dec && !step_inc && dec_ok;
      wire do_wr = wr_en && hit_wiper[n];

      // Writes land regardless of shutdown state
      assign wiper_nxt[n] = do_wr ? pwdata_in[WIPER_W-1:0] :
                            do_inc ? 9'(code + ONE_CODE) :
                            do_dec ? 9'(code - ONE_CODE) :
                            code;

      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          wiper_r[n] <= MID;
        end else begin
          wiper_r[n] <= wiper_nxt[n];
        end
      end

      assign shdn_now[n] = !terminal_control_reg_app_r[n*TERMINAL_CONTROL_REG_NET_STRIDE + TERMINAL_CONTROL_REG_HW_OFS];
      assign full_now[n] = (code >= FS);

      if (n < NUM_NETS) begin : g_live
        // Zero decodes to B tap, full scale to A tap
        wtc_tap_decode #(
          .EIGHT_BIT(EIGHT_BIT)
        ) u_dec (
          .clk_in(clk_in),
          .arst_n_in(arst_n_in),
          .code_in(code),
          .terminal_control_reg_nib_in(terminal_control_reg_app_r[n*TERMINAL_CONTROL_REG_NET_STRIDE +: TERMINAL_CONTROL_REG_NET_STRIDE]),
          .tap_sel_out(tap_sel[n]),
          .term_a_out(pin_a[n]),
          .wiper_out(pin_w[n]),
          .term_b_out(pin_b[n])
        );
      end else begin : g_absent
        // Missing network keeps every switch open
        assign tap_sel[n] = '0;
        assign pin_a[n] = 1'b0;
        assign pin_w[n] = 1'b0;
        assign pin_b[n] = 1'b0;
      end
    end
  endgenerate

  // Terminal control: stored copy and the copy that drives the switches
  wire [TERMINAL_CONTROL_REG_W-1:0] terminal_control_reg_nxt = (wr_en && hit_terminal_control_reg) ? pwdata_in[TERMINAL_CONTROL_REG_W-1:0] : terminal_control_reg_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      terminal_control_reg_r <= TERMINAL_CONTROL_REG_RESET;
      terminal_control_reg_app_r <= TERMINAL_CONTROL_REG_RESET;
    end else begin
      terminal_control_reg_r <= terminal_control_reg_nxt;
      // Switches follow only once the bus write has finished
      terminal_control_reg_app_r <= terminal_control_reg_r;
    end
  end

  // Read mux; reserved status bits read as zero, the reserved register reads RSVD5_VALUE
  wire [31:0] stat_word = {22'h000000,
                           EIGHT_BIT,
                           (NUM_NETS > 1),
                           2'b00,
                           full_now,
                           2'b00,
                           shdn_now};
  wire [31:0] rd_mux = hit_w0 ? {23'h000000, wiper_r[0]} :
                       hit_w1 ? {23'h000000, wiper_r[1]} :
                       hit_terminal_control_reg ? {23'h000000, terminal_control_reg_r} :
                       hit_rsvd5 ? {23'h000000, RSVD5_VALUE} :
                       hit_stat ? stat_word :
                       32'h0000_0000;

  // Read data captured in setup so it is steady through the access phase
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_r <= PRDATA_RESET;
    end else if (setup_ph && !pwrite_in) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata_out = prdata_r;
  assign gcen_out = terminal_control_reg_app_r[TERMINAL_CONTROL_REG_GCEN_BIT];

  assign net0_tap_sel_out = tap_sel[0];
  assign net0_term_a_pin_out = pin_a[0];
  assign net0_wiper_pin_out = pin_w[0];
  assign net0_term_b_pin_out = pin_b[0];
  assign net1_tap_sel_out = tap_sel[1];
  assign net1_term_a_pin_out = pin_a[1];
  assign net1_wiper_pin_out = pin_w[1];
  assign net1_term_b_pin_out = pin_b[1];

endmodule

// *** tb/wtc_ctrl_checker.sv ***
`timescale 1ns/1ps
module wtc_ctrl_checker
  import wtc_pkg::*;
#(
  parameter bit EIGHT_BIT = 1'b1
) (
  // Bus
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  // Network 0
  input wire logic [TAP_N-1:0] net0_tap_sel_out,
  input wire logic net0_term_a_pin_out,
  input wire logic net0_wiper_pin_out,
  input wire logic net0_term_b_pin_out
);
  localparam logic [8:0] FS = EIGHT_BIT ? FS_8BIT : FS_7BIT;
  localparam logic [8:0] MID = EIGHT_BIT ? MID_8BIT : MID_7BIT;
  localparam logic [TAP_N-1:0] ONE = {{(TAP_N-1){1'b0}}, 1'b1};
  logic up_r;
  logic [3:0] tc_r, tc_d_r, pv_r;
  wire acc = psel_in & penable_in & pwrite_in;
  wire tc_wr = acc & (paddr_in == ADDR_TERMINAL_CONTROL_REG);
  wire [8:0] wcode = (pwdata_in[8:0] > FS) ? FS : pwdata_in[8:0];
  // Shadow of the applied copy, two stages behind the write
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      up_r <= 1'b0;
      tc_r <= 4'hf;
      tc_d_r <= 4'hf;
      pv_r <= 4'hf;
    end else begin
      up_r <= 1'b1;
      if (tc_wr) tc_r <= pwdata_in[3:0];
      tc_d_r <= tc_r;
      pv_r <= tc_d_r;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_wr0;
    acc && paddr_in == ADDR_WIPER0 && tc_r[3];
  endsequence
  // Register lands at the access edge, the decode flop one edge later
  a_wr_tap: assert property (s_wr0 |-> ##2 net0_tap_sel_out == (ONE << $past(wcode, 2)))
    else $error("tap select wrong after wiper write");
  a_one_hot: assert property (up_r |-> $onehot(net0_tap_sel_out))
    else $error("tap select not one-hot");
  a_reset_mid: assert property ($rose(up_r) |-> net0_tap_sel_out == (ONE << MID))
    else $error("tap not at mid scale after reset");
  a_term_a: assert property (up_r |-> net0_term_a_pin_out == (pv_r[3] & pv_r[2]))
    else $error("terminal a switch wrong");
  a_wiper_sw: assert property (up_r |-> net0_wiper_pin_out == (!pv_r[3] | pv_r[1]))
    else $error("wiper switch wrong");
  a_term_b: assert property (up_r |-> net0_term_b_pin_out == (!pv_r[3] | pv_r[0]))
    else $error("terminal b switch wrong");
  a_shdn_tap: assert property (up_r && !pv_r[3] |-> net0_tap_sel_out[0])
    else $error("shutdown tap not at b end");
  a_tc_late: assert property (tc_wr |-> ##2 $stable(net0_term_a_pin_out))
    else $error("terminal control applied too early");
  a_no_wait: assert property (psel_in && penable_in |-> pready_out)
    else $error("bus access not answered");
endmodule

bind wtc_ctrl wtc_ctrl_checker #(.EIGHT_BIT(EIGHT_BIT)) u_chk (.clk_in, .arst_n_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .net0_tap_sel_out,
  .net0_term_a_pin_out, .net0_wiper_pin_out, .net0_term_b_pin_out);

// *** tb/wtc_ladder_model.sv ***
`timescale 1ns/1ps
module wtc_ladder_model
  import wtc_pkg::*;
(
  // Switch drives
  input wire logic [TAP_N-1:0] tap_in,
  // Ladder view
  output int pos_out,
  output int closed_out
);
  // The ladder only sees closed switches, never the code
  always_comb begin
    pos_out = -1;
    closed_out = 0;
    for (int k = 0; k < TAP_N; k++) begin
      if (tap_in[k] === 1'b1) begin
        pos_out = k;
        closed_out++;
      end
    end
  end
endmodule

// *** tb/wtc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module wtc_ctrl_tb_top;
  import wtc_pkg::*;
  localparam int FS = 256;
  localparam int FS7 = 128;
  localparam int SV[8] = '{0, 1, 255, 256, 257, 511, 128, 200};
  logic clk_in = 0, arst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, rd;
  logic pready_out, pslverr_out, gcen_out, er, a0, w0, b0, a1, w1, b1;
  logic [TAP_N-1:0] t0, t1;
  int err_count = 0, checked = 0, seed = 61251, cyc = 0, p0, p1, c0, c1, v, n, tc;
  int wm[2];
  int p7, c7, wm7;
  logic [31:0] prd7, rd7;
  logic rdy7, err7, gc7, er7, a7, w7, b7, a7b, w7b, b7b;
  logic [TAP_N-1:0] t7, t7b;
  always #25 clk_in = ~clk_in;
  wtc_ctrl dut (.clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .gcen_out, .net0_tap_sel_out(t0),
    .net0_term_a_pin_out(a0), .net0_wiper_pin_out(w0), .net0_term_b_pin_out(b0),
    .net1_tap_sel_out(t1), .net1_term_a_pin_out(a1), .net1_wiper_pin_out(w1),
    .net1_term_b_pin_out(b1));
  wtc_ladder_model m0 (.tap_in(t0), .pos_out(p0), .closed_out(c0));
  wtc_ladder_model m1 (.tap_in(t1), .pos_out(p1), .closed_out(c1));
  // Seven-bit single-network build on the same bus
  wtc_ctrl #(.NUM_NETS(1), .EIGHT_BIT(1'b0)) dut7 (.clk_in, .arst_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out(prd7), .pready_out(rdy7),
    .pslverr_out(err7), .gcen_out(gc7), .net0_tap_sel_out(t7), .net0_term_a_pin_out(a7),
    .net0_wiper_pin_out(w7), .net0_term_b_pin_out(b7), .net1_tap_sel_out(t7b),
    .net1_term_a_pin_out(a7b), .net1_wiper_pin_out(w7b), .net1_term_b_pin_out(b7b));
  wtc_ladder_model m7 (.tap_in(t7), .pos_out(p7), .closed_out(c7));
  task close_out;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, well above the roughly 1080 cycles needed
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      close_out();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    rd7 = prd7;
    er7 = err7;
    chk(rdy7, 1);
    psel_in <= 0;
    penable_in <= 0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task chkn(input int k);
    int h;
    h = tc >> (4 * k + 3) & 1;
    chk(k ? p1 : p0, h ? (wm[k] > FS ? FS : wm[k]) : 0);
    chk(k ? c1 : c0, 1);
    chk(k ? {a1, w1, b1} : {a0, w0, b0}, h ? tc >> (4 * k) & 7 : 3);
    chk(gcen_out, tc >> 8 & 1);
    if (k == 0) begin
      chk(p7, h ? (wm7 > FS7 ? FS7 : wm7) : 0);
      chk(c7, 1);
      chk({a7, w7, b7}, h ? tc & 7 : 3);
      chk(gc7, tc >> 8 & 1);
      chk({t7b != 0, a7b, w7b, b7b}, 0);
    end
  endtask
  task chks;
    int e;
    e = 'h300;
    if (wm[0] >= FS) e += 'h10;
    if (wm[1] >= FS) e += 'h20;
    if (!(tc >> 3 & 1)) e += 'h1;
    if (!(tc >> 7 & 1)) e += 'h2;
    apb(0, ADDR_STATUS, 0);
    chk(rd, e);
  endtask
  task wrw(input int k, input int d);
    apb(1, k ? ADDR_WIPER1 : ADDR_WIPER0, d);
    wm[k] = d;
    if (k == 0) wm7 = d;
  endtask
  task step(input int k, input int inc, input int dec);
    apb(1, ADDR_STEP_CMD, k << 4 | dec << 1 | inc);
    if (inc && !dec && wm[k] < FS) wm[k]++;
    if (dec && !inc && wm[k] > 0 && wm[k] <= FS) wm[k]--;
    if (k == 0 && inc && !dec && wm7 < FS7) wm7++;
    if (k == 0 && dec && !inc && wm7 > 0 && wm7 <= FS7) wm7--;
    chkn(k);
  endtask
  initial begin
    wm = '{128, 128};
    wm7 = 64;
    tc = 'h1ff;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1;
    @(posedge clk_in);
    #1;
    chkn(0);
    chkn(1);
    apb(0, ADDR_TERMINAL_CONTROL_REG, 0);
    chk(rd, 'h1ff);
    apb(0, ADDR_RSVD5, 0);
    chk(rd, 'h1f7);
    for (int i = 0; i < 24; i++) begin
      n = i & 1;
      v = (i < 8) ? SV[i / 2 + 2] : $random(seed) & 'h1ff;
      wrw(n, v);
      chkn(n);
      apb(0, n ? ADDR_WIPER1 : ADDR_WIPER0, 0);
      chk(rd, v);
      chk(rd7, n ? 0 : v);
      chk(er7, n);
      chk(er, 0);
    end
    for (int i = 0; i < 16; i++) begin
      n = i & 1;
      wrw(n, SV[i / 2]);
      for (int k = 1; k < 4; k++) step(n, k & 1, k >> 1);
      chks();
    end
    for (int i = 0; i < 12; i++) begin
      tc = (i == 11) ? 'h1ff : $random(seed) & 'h1ff;
      apb(1, ADDR_TERMINAL_CONTROL_REG, tc);
      chkn(1);
      v = $random(seed) & 'hff;
      wrw(0, v);
      chkn(0);
      apb(0, ADDR_WIPER0, 0);
      chk(rd, v);
      chks();
    end
    apb(0, 12'h008, 0);
    chk(er, 1);
    chk(rd, 0);
    chk(er7, 1);
    close_out();
  end
endmodule
